/* File: design/ebc_defines.svh */
// Constants for the external bus area controller.
// Assumes a single 20 MHz clock and 24-bit internal addresses.
//
// Contract
// - After reset all areas are basic, three-state; width default follows mode.
// - Advanced, ROM off: area 0 fully external; ROM on: outside ROM only.
// - Area 0 may be burst ROM type; other advanced areas basic only.
// - Areas 0 to 6 are 128 kbytes or 2 Mbytes per unit select.
// - Expansion mode: areas 1 to 6 external; chip selects 1-3 follow areas 1-3.
// - Area 7 holds RAM and I/O, basic only; remainder external in expansion.
// - Area 7 is 15 Mbytes or 2 Mbytes per unit select.
// - RAM enable 1 routes RAM addresses on-chip; 0 makes them external.
// - Normal mode uses a 64-kbyte part of area 0, no partitioning.
// - Normal mode external space excludes ROM if enabled, RAM and I/O.
// - Advanced: chip selects 0-3 low during matching access; normal: only 0.
// - Chip selects drive only when direction set; ROM off: 0 output after reset.
// - ROM on: all chip select pins inputs after reset until software sets them; code keeps 0 an output until the straps are synchronised.
// - On-chip ROM and RAM accesses take one state, 16-bit path; code reads a longword in one state over 32 bits.
// - Peripheral register accesses take two states.
// - External accesses use two or three states; waits only for three-state.
// - 8-bit space uses upper lane; word is two bytes, longword four.
// - 16-bit space moves byte or word; longword is two words.
// - 16-bit byte access: even address upper lane, odd lower lane.
// - Reads assert the single read strobe whatever lanes are used.
// - Upper strobe qualifies upper lane, lower strobe lower; word writes both.
// - Unused lane is high impedance on byte writes, ignored on reads.
// - Unit select 0 gives 128-kbyte areas, 1 gives 2 Mbytes; resets to 1.
// - Lower write strobe stays high throughout 8-bit space accesses.
// - Three-state areas insert zero to three programmed waits per area.
`ifndef EBC_DEFINES_SVH
`define EBC_DEFINES_SVH

// Address map
`define ROM_LAST          24'h01FFFF
`define RAM_BASE          24'hFFB000
`define RAM_LAST          24'hFFEFFF
`define IO_BASE           24'hFFF000
`define N_ROM_LAST        16'hBFFF
`define N_RAM_BASE        16'hF000
`define N_RAM_LAST        16'hFEFF
`define N_IO_BASE         16'hFF00
`define AREA7_SMALL       7'h07

// Reset values
`define UNIT_SELECT_RST   1'b1
`define RAM_ENABLE_RST    1'b1
`define STATE_CTRL_RST    8'hFF
`define WAIT_CTRL_RST     16'hFFFF
`define WIDTH_RST_ROM_ON  8'hFF
`define WIDTH_RST_ROM_OFF 8'h00

// State counts
`define MEM_STATES        3'h1
`define IO_STATES         3'h2
`define EXT2_STATES       3'h2
`define EXT3_STATES       3'h3

`endif

/* File: design/ebc_pkg.sv */
// Types shared by the external bus area controller.
// Assumes ebc_defines.svh for all numeric constants.
package ebc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_INT  = 3'b010,
    ST_EXT  = 3'b100
  } state_e;

  typedef enum logic [4:0] {
    SP_ROM  = 5'b00001,
    SP_RAM  = 5'b00010,
    SP_IO   = 5'b00100,
    SP_EXT  = 5'b01000,
    SP_NONE = 5'b10000
  } space_e;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_LONG = 2'b10
  } size_e;

  typedef struct packed {
    state_e      state;
    logic        area_unit_select;
    logic        onchip_ram_enable;
    logic        width_set;
    logic [7:0]  area_width_control;
    logic [7:0]  area_state_control;
    logic [15:0] wait_control;
    logic        burst_area0;
    logic        dir_set;
    logic [3:0]  cs_dir;
    logic [23:0] base;
    size_e       size;
    logic        write;
    logic [31:0] wdata;
    space_e      space;
    logic [2:0]  area;
    logic        wide;
    logic        three;
    logic [1:0]  offs;
    logic [2:0]  cnt;
    logic [2:0]  last;
    logic        use_hi;
    logic        use_lo;
    logic [31:0] rdata;
    logic [23:0] bus_addr;
    logic [15:0] dout;
    logic        oe_hi;
    logic        oe_lo;
    logic        rd_n;
    logic        hwr_n;
    logic        lwr_n;
    logic [3:0]  cs_n;
    logic        resp_valid;
    logic [31:0] resp_data;
  } ctrl_s;

  typedef struct packed {
    logic [2:0] f1;
    logic [2:0] f2;
    logic [2:0] f3;
    logic [2:0] out;
  } sync_s;

endpackage

/* File: design/decode_if.sv */
// Address decode request and result between controller and decoder.
// Assumes a combinational decoder on the same clock.
interface decode_if;
  logic               [23:0] addr;
  logic                      advanced;
  logic                      rom_enable;
  logic                      expansion;
  logic                      area_unit_select;
  logic                      onchip_ram_enable;
  logic               [2:0]  area;
  ebc_pkg::space_e           space;

  modport requester (
    output addr, advanced, rom_enable, expansion, area_unit_select, onchip_ram_enable,
    input  area, space
  );
  modport decoder (
    input  addr, advanced, rom_enable, expansion, area_unit_select, onchip_ram_enable,
    output area, space
  );
endinterface

/* File: design/strap_sync.sv */
// Three-stage synchroniser for the mode straps.
// Assumes straps are static pins; output follows once stages two and three agree.
module strap_sync (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  // Pins
  input  wire logic [2:0] i_pins,
  // Synchronised levels
  output logic      [2:0] o_levels
);
  ebc_pkg::sync_s r_reg;
  ebc_pkg::sync_s r_next;

  always_comb begin
    r_next = r_reg;
    r_next.f1 = i_pins;
    r_next.f2 = r_reg.f1;
    r_next.f3 = r_reg.f2;
    if (r_reg.f2 == r_reg.f3) begin
      r_next.out = r_reg.f3;
    end
    if (i_rst) begin
      r_next = '0;
    end
  end

  always_ff @(posedge i_clock) begin
    r_reg <= r_next;
  end

  assign o_levels = r_reg.out;
endmodule

/* File: design/area_decoder.sv */
// Address to area and space decoder.
// Assumes a 24-bit advanced map and a 64-kbyte normal map.
`include "ebc_defines.svh"
module area_decoder (
  decode_if.decoder dec
);
  logic [23:0] a;
  logic [15:0] a16;
  logic        rom_hit;
  logic        ram_hit;
  logic        io_hit;

  always_comb begin
    a   = dec.addr;
    a16 = dec.addr[15:0];
    if (dec.advanced) begin
      rom_hit = dec.rom_enable && (a <= `ROM_LAST);
      ram_hit = dec.onchip_ram_enable && (a >= `RAM_BASE) && (a <= `RAM_LAST);
      io_hit  = a >= `IO_BASE;
      if (dec.area_unit_select) begin
        dec.area = a[23:21];
      end else if (a[23:17] < `AREA7_SMALL) begin
        dec.area = a[19:17];
      end else begin
        dec.area = 3'h7;
      end
    end else begin
      rom_hit  = dec.rom_enable && (a16 <= `N_ROM_LAST);
      ram_hit  = dec.onchip_ram_enable && (a16 >= `N_RAM_BASE) && (a16 <= `N_RAM_LAST);
      io_hit   = a16 >= `N_IO_BASE;
      dec.area = 3'h0;
    end
    if (io_hit) begin
      dec.space = ebc_pkg::SP_IO;
    end else if (ram_hit) begin
      dec.space = ebc_pkg::SP_RAM;
    end else if (rom_hit) begin
      dec.space = ebc_pkg::SP_ROM;
    end else if (dec.expansion) begin
      dec.space = ebc_pkg::SP_EXT;
    end else begin
      dec.space = ebc_pkg::SP_NONE;
    end
  end
endmodule

/* File: design/ext_bus_ctrl.sv */
// External bus area controller: area decode, state counts, lane alignment.
// Assumes one internal master with a valid/ready request and mode straps on pins.
`include "ebc_defines.svh"
module ext_bus_ctrl (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // Mode straps
  input  wire logic        i_advanced_mode,
  input  wire logic        i_rom_enable,
  input  wire logic        i_expansion_mode,
  // Configuration load
  input  wire logic        i_cfg_load,
  input  wire logic        i_area_unit_select,
  input  wire logic        i_onchip_ram_enable,
  input  wire logic [7:0]  i_area_width_control,
  input  wire logic [7:0]  i_area_state_control,
  input  wire logic [15:0] i_wait_control,
  input  wire logic        i_burst_rom_area0,
  input  wire logic [3:0]  i_cs_direction,
  // Internal master request
  input  wire logic        i_req_valid,
  input  wire logic [23:0] i_req_addr,
  input  wire logic        i_req_write,
  input  wire logic [1:0]  i_req_size,
  input  wire logic [31:0] i_req_wdata,
  output logic             o_req_ready,
  output logic             o_resp_valid,
  output logic      [31:0] o_resp_rdata,
  // On-chip memory and peripheral side
  output logic             o_int_access,
  output logic             o_int_io,
  input  wire logic [31:0] i_int_rdata,
  // External pins
  output logic      [23:0] o_addr,
  output logic      [15:0] o_data_out,
  output logic             o_data_oe_upper,
  output logic             o_data_oe_lower,
  input  wire logic [15:0] i_data_in,
  output logic             o_read_strobe_n,
  output logic             o_upper_write_strobe_n,
  output logic             o_lower_write_strobe_n,
  output logic      [3:0]  o_chip_select_n,
  output logic      [3:0]  o_chip_select_oe
);
  ebc_pkg::ctrl_s r_reg;
  ebc_pkg::ctrl_s r_next;
  logic [2:0]     straps;
  logic           adv;
  logic           rom_en;
  logic           expn;
  logic [7:0]     eff_width;
  logic [3:0]     eff_dir;
  logic           accept;
  decode_if       dec ();

  strap_sync u_sync (
    .i_clock  (i_clock),
    .i_rst    (i_rst),
    .i_pins   ({i_expansion_mode, i_rom_enable, i_advanced_mode}),
    .o_levels (straps)
  );

  area_decoder u_dec (
    .dec (dec.decoder)
  );

  // Synchronised strap levels
  assign adv    = straps[0];
  assign rom_en = straps[1];
  assign expn   = straps[2];

  assign dec.addr              = i_req_addr;
  assign dec.advanced          = adv;
  assign dec.rom_enable        = rom_en;
  assign dec.expansion         = expn;
  assign dec.area_unit_select  = r_reg.area_unit_select;
  assign dec.onchip_ram_enable = r_reg.onchip_ram_enable;

  // Mode dependent defaults until software loads configuration
  assign eff_width = r_reg.width_set ? r_reg.area_width_control :
                     (rom_en ? `WIDTH_RST_ROM_ON : `WIDTH_RST_ROM_OFF);
  assign eff_dir   = r_reg.dir_set ? r_reg.cs_dir : {3'h0, ~rom_en};

  function automatic logic [2:0] nbytes(ebc_pkg::size_e s);
    unique case (s)
      ebc_pkg::SZ_WORD: nbytes = 3'h2;
      ebc_pkg::SZ_LONG: nbytes = 3'h4;
      default:          nbytes = 3'h1;
    endcase
  endfunction

  // Active-low write strobe for one byte lane
  function automatic logic strobe_n(logic wr, logic lane, logic on);
    strobe_n = !(wr && lane && on);
  endfunction

  // Byte k of the request, most significant byte first
  function automatic logic [7:0] req_byte(logic [31:0] d, logic [2:0] n, logic [1:0] k);
    logic [1:0]  idx;
    logic [31:0] sh;
    idx      = 2'(n - 3'h1 - {1'b0, k});
    sh       = d >> {idx, 3'h0};
    req_byte = sh[7:0];
  endfunction

  // Launch one bus piece: address, lanes, strobes, state count
  function automatic ebc_pkg::ctrl_s start_piece(ebc_pkg::ctrl_s s, logic a);
    ebc_pkg::ctrl_s t;
    logic [23:0]    pa;
    logic [2:0]     nb;
    logic [7:0]     b0;
    logic [7:0]     b1;
    logic [1:0]     wt;
    logic           hi;
    logic           lo;
    t  = s;
    pa = s.base + {22'h0, s.offs};
    nb = nbytes(s.size);
    b0 = req_byte(s.wdata, nb, s.offs);
    b1 = req_byte(s.wdata, nb, 2'(s.offs + 2'h1));
    wt = s.wait_control[{s.area, 1'b0} +: 2];
    t.cnt      = 3'h0;
    t.bus_addr = a ? pa : {8'h00, pa[15:0]};
    t.oe_hi    = 1'b0;
    t.oe_lo    = 1'b0;
    t.rd_n     = 1'b1;
    t.hwr_n    = 1'b1;
    t.lwr_n    = 1'b1;
    t.cs_n     = 4'hF;
    t.use_hi   = 1'b0;
    t.use_lo   = 1'b0;
    if (s.space == ebc_pkg::SP_EXT) begin
      t.state = ebc_pkg::ST_EXT;
      if (s.offs != 2'h0) begin
        // Later pieces keep the first count, so a mid-access load waits
        t.last = s.last;
      end else if (s.three) begin
        t.last = 3'(`EXT3_STATES - 3'h1 + {1'b0, wt});
      end else begin
        t.last = `EXT2_STATES - 3'h1;
      end
      if (!s.wide) begin
        hi = 1'b1;
        lo = 1'b0;
      end else if (s.size == ebc_pkg::SZ_BYTE) begin
        hi = ~pa[0];
        lo = pa[0];
      end else begin
        hi = 1'b1;
        lo = 1'b1;
      end
      t.use_hi = hi;
      t.use_lo = lo;
      t.dout   = (hi && lo) ? {b0, b1} : {b0, b0};
      t.oe_hi  = s.write && hi;
      t.oe_lo  = s.write && lo;
      t.rd_n   = s.write;
      t.hwr_n  = strobe_n(s.write, hi, !s.three);
      t.lwr_n  = strobe_n(s.write, lo, !s.three);
      if (s.area < 3'h4 && (a || s.area == 3'h0)) begin
        t.cs_n[s.area[1:0]] = 1'b0;
      end
    end else begin
      t.state = ebc_pkg::ST_INT;
      if (s.space == ebc_pkg::SP_IO) begin
        t.last = `IO_STATES - 3'h1;
      end else begin
        t.last = `MEM_STATES - 3'h1;
      end
    end
    start_piece = t;
  endfunction

  // Requests are taken only in idle
  assign accept = (r_reg.state == ebc_pkg::ST_IDLE) && i_req_valid;

  always_comb begin
    logic [7:0]  lane;
    logic [31:0] rd;
    logic [2:0]  pb;
    logic [2:0]  nxt;
    lane = r_reg.use_hi ? i_data_in[15:8] : i_data_in[7:0];
    rd   = (r_reg.use_hi && r_reg.use_lo) ? {r_reg.rdata[15:0], i_data_in} :
                                             {r_reg.rdata[23:0], lane};
    pb   = (r_reg.use_hi && r_reg.use_lo) ? 3'h2 : 3'h1;
    nxt  = {1'b0, r_reg.offs} + pb;
    r_next = r_reg;
    r_next.resp_valid = 1'b0;

    // Configuration load, applies from the next request; a request taken in the same cycle already uses the new wait count
    if (i_cfg_load) begin
      r_next.area_unit_select   = i_area_unit_select;
      r_next.onchip_ram_enable  = i_onchip_ram_enable;
      r_next.area_width_control = i_area_width_control;
      r_next.area_state_control = i_area_state_control;
      r_next.wait_control       = i_wait_control;
      r_next.burst_area0        = i_burst_rom_area0;
      r_next.cs_dir             = i_cs_direction;
      r_next.width_set          = 1'b1;
      r_next.dir_set            = 1'b1;
    end

    // Access sequencer
    unique case (r_reg.state)
      ebc_pkg::ST_IDLE: begin
        if (accept) begin
          r_next.base  = i_req_addr;
          r_next.size  = ebc_pkg::size_e'(i_req_size);
          r_next.write = i_req_write;
          r_next.wdata = i_req_wdata;
          r_next.space = dec.space;
          r_next.area  = dec.area;
          // Burst ROM area 0 is always a 16-bit space
          r_next.wide  = !eff_width[dec.area] ||
                         (dec.area == 3'h0 && r_reg.burst_area0);
          r_next.three = r_reg.area_state_control[dec.area];
          r_next.offs  = 2'h0;
          r_next.rdata = 32'h0000_0000;
          r_next       = start_piece(r_next, adv);
        end
      end
      ebc_pkg::ST_INT: begin
        if (r_reg.cnt == r_reg.last) begin
          r_next.resp_valid = 1'b1;
          r_next.resp_data  = (r_reg.space == ebc_pkg::SP_NONE) ? 32'h0000_0000 :
                              i_int_rdata;
          r_next.state      = ebc_pkg::ST_IDLE;
        end else begin
          r_next.cnt = 3'(r_reg.cnt + 3'h1);
        end
      end
      ebc_pkg::ST_EXT: begin
        if (r_reg.cnt == r_reg.last) begin
          if (!r_reg.write) begin
            r_next.rdata = rd;
          end
          r_next.oe_hi = 1'b0;
          r_next.oe_lo = 1'b0;
          r_next.rd_n  = 1'b1;
          r_next.hwr_n = 1'b1;
          r_next.lwr_n = 1'b1;
          r_next.cs_n  = 4'hF;
          if (nxt == nbytes(r_reg.size)) begin
            r_next.resp_valid = 1'b1;
            r_next.resp_data  = r_reg.write ? 32'h0000_0000 : rd;
            r_next.state      = ebc_pkg::ST_IDLE;
          end else begin
            r_next.offs = nxt[1:0];
            r_next      = start_piece(r_next, adv);
          end
        end else begin
          r_next.cnt = 3'(r_reg.cnt + 3'h1);
          if (r_reg.three) begin
            r_next.hwr_n = strobe_n(r_reg.write, r_reg.use_hi, 1'b1);
            r_next.lwr_n = strobe_n(r_reg.write, r_reg.use_lo, 1'b1);
          end
        end
      end
    endcase

    // Synchronous reset overrides all
    if (i_rst) begin
      r_next                    = '0;
      r_next.state              = ebc_pkg::ST_IDLE;
      r_next.space              = ebc_pkg::SP_NONE;
      r_next.area_unit_select   = `UNIT_SELECT_RST;
      r_next.onchip_ram_enable  = `RAM_ENABLE_RST;
      r_next.area_state_control = `STATE_CTRL_RST;
      r_next.wait_control       = `WAIT_CTRL_RST;
      r_next.rd_n               = 1'b1;
      r_next.hwr_n              = 1'b1;
      r_next.lwr_n              = 1'b1;
      r_next.cs_n               = 4'hF;
    end
  end

  // State register
  always_ff @(posedge i_clock) begin
    r_reg <= r_next;
  end

  // Request handshake and answer
  assign o_req_ready            = r_reg.state == ebc_pkg::ST_IDLE;
  assign o_resp_valid           = r_reg.resp_valid;
  assign o_resp_rdata           = r_reg.resp_data;

  // On-chip access qualifiers
  assign o_int_access           = (r_reg.state == ebc_pkg::ST_INT) &&
                                  (r_reg.space != ebc_pkg::SP_NONE);
  assign o_int_io               = o_int_access && (r_reg.space == ebc_pkg::SP_IO);

  // External pins, all from flops except direction
  assign o_addr                 = r_reg.bus_addr;
  assign o_data_out             = r_reg.dout;
  assign o_data_oe_upper        = r_reg.oe_hi;
  assign o_data_oe_lower        = r_reg.oe_lo;
  assign o_read_strobe_n        = r_reg.rd_n;
  assign o_upper_write_strobe_n = r_reg.hwr_n;
  assign o_lower_write_strobe_n = r_reg.lwr_n;
  assign o_chip_select_n        = r_reg.cs_n;
  assign o_chip_select_oe       = eff_dir;
endmodule

/* File: tb/ext_bus_ctrl_monitor.sv */
// Assertions on the external bus area controller pins.
// Assumes binding into ext_bus_ctrl; sees only its ports.
module ext_bus_ctrl_monitor (
  // Clock and reset
  input wire logic       i_clock,
  input wire logic       i_rst,
  // Request side
  input wire logic       i_req_valid,
  input wire logic       o_req_ready,
  input wire logic       o_resp_valid,
  input wire logic       o_int_access,
  input wire logic       o_int_io,
  // Pins
  input wire logic       o_data_oe_upper,
  input wire logic       o_data_oe_lower,
  input wire logic       o_read_strobe_n,
  input wire logic       o_upper_write_strobe_n,
  input wire logic       o_lower_write_strobe_n,
  input wire logic [3:0] o_chip_select_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence s_take;
    i_req_valid && o_req_ready;
  endsequence
  sequence s_mem;
    o_int_access && !o_int_io;
  endsequence

  a_reset_idle: assert property (disable iff (1'b0)
    i_rst |=> o_req_ready && o_chip_select_n == 4'hF && o_read_strobe_n)
    else $error("pins not idle after reset");
  a_mem_one_state: assert property (s_take ##1 s_mem |=> o_resp_valid)
    else $error("on-chip memory answer not after one state");
  a_io_two_states: assert property (s_take ##1 o_int_io |=> !o_resp_valid ##1 o_resp_valid)
    else $error("peripheral answer not after two states");
  a_upper_lane_wr: assert property (!o_upper_write_strobe_n |-> o_data_oe_upper)
    else $error("upper strobe without upper lane driven");
  a_lower_lane_wr: assert property (!o_lower_write_strobe_n |-> o_data_oe_lower)
    else $error("lower strobe without lower lane driven");
  a_read_lanes_free: assert property (!o_read_strobe_n |-> !o_data_oe_upper && !o_data_oe_lower)
    else $error("data lane driven during read");
  a_read_alone: assert property ($fell(o_read_strobe_n) |-> o_upper_write_strobe_n && o_lower_write_strobe_n)
    else $error("read and write strobes together");
  a_cs_idle_high: assert property (o_req_ready |-> o_chip_select_n == 4'hF)
    else $error("chip select low while idle");
  a_cs_ext_only: assert property (o_chip_select_n != 4'hF |-> !o_int_access && $countones(~o_chip_select_n) == 1)
    else $error("chip select during internal access or several low");
endmodule

bind ext_bus_ctrl ext_bus_ctrl_monitor i_mon (
  .i_clock, .i_rst, .i_req_valid, .o_req_ready, .o_resp_valid, .o_int_access, .o_int_io,
  .o_data_oe_upper, .o_data_oe_lower, .o_read_strobe_n, .o_upper_write_strobe_n,
  .o_lower_write_strobe_n, .o_chip_select_n
);

/* File: tb/ext_mem_model.sv */
// External byte memory on the data bus, 256 bytes by low address.
// Assumes 2-Mbyte areas for its own width lookup.
module ext_mem_model (
  // Clock
  input  wire logic        i_clock,
  // Bus pins
  input  wire logic [23:0] i_addr,
  input  wire logic [15:0] i_data,
  input  wire logic        i_read_n,
  input  wire logic        i_upper_write_n,
  input  wire logic        i_lower_write_n,
  // Area widths, 1 = 8-bit
  input  wire logic [7:0]  i_narrow,
  output logic      [15:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [256];
  logic [15:0] last = 16'h0000;
  logic        narrow;
  logic [7:0]  ev;
  logic [7:0]  od;
  assign narrow = i_narrow[i_addr[23:21]];
  assign ev = narrow ? i_addr[7:0] : {i_addr[7:1], 1'b0};
  assign od = {i_addr[7:1], 1'b1};
  always @(posedge i_clock) begin
    if (!i_upper_write_n) mem[ev] <= i_data[15:8];
    if (!i_lower_write_n) mem[od] <= i_data[7:0];
    if (!i_read_n) last <= o_data;
  end
  always_comb begin
    if (i_read_n) o_data = ~last;
    else if (narrow) o_data = {mem[ev], ~last[7:0]};
    else o_data = {mem[ev], mem[od]};
  end
endmodule

/* File: tb/tb_ext_bus_ctrl.sv */
// Self-checking bench for ext_bus_ctrl with an external memory model.
// Runs advanced expansion mode with on-chip ROM off, then normal expansion mode with ROM on.
module tb_ext_bus_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [23:0] a;
    logic        w;
    logic [1:0]  sz;
    logic [31:0] wd;
    logic [31:0] rd;
    int          lat;
    logic [3:0]  cs;
    logic [1:0]  wr;
  } row_s;
  localparam logic [31:0] INT_DATA = 32'h5A5AC3C3;
  logic        i_clock = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_advanced_mode = 1'b1;
  logic        i_rom_enable = 1'b0;
  logic        i_expansion_mode = 1'b1;
  logic        i_cfg_load = 1'b0;
  logic        i_area_unit_select = 1'b1;
  logic        i_onchip_ram_enable = 1'b1;
  logic [7:0]  i_area_width_control = 8'h04;
  logic [7:0]  i_area_state_control = 8'h02;
  logic [15:0] i_wait_control = 16'h0004;
  logic        i_burst_rom_area0 = 1'b0;
  logic [3:0]  i_cs_direction = 4'h0;
  logic        i_req_valid = 1'b0;
  logic [23:0] i_req_addr = 24'h000000;
  logic        i_req_write = 1'b0;
  logic [1:0]  i_req_size = 2'h0;
  logic [31:0] i_req_wdata = 32'h00000000;
  logic [31:0] i_int_rdata = INT_DATA;
  logic [15:0] i_data_in;
  logic        o_req_ready, o_resp_valid, o_int_access, o_int_io;
  logic [31:0] o_resp_rdata;
  logic [23:0] o_addr;
  logic [15:0] o_data_out;
  logic        o_data_oe_upper, o_data_oe_lower, o_read_strobe_n;
  logic        o_upper_write_strobe_n, o_lower_write_strobe_n;
  logic [3:0]  o_chip_select_n, o_chip_select_oe;
  int          errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  row_s rows [13] = '{
    '{24'h600010, 1'b1, 2'h2, 32'h11223344, 32'h00000000, 5, 4'h8, 2'h3},
    '{24'h600015, 1'b1, 2'h0, 32'h000000AA, 32'h00000000, 3, 4'h8, 2'h1},
    '{24'h200020, 1'b1, 2'h1, 32'h00005566, 32'h00000000, 5, 4'h2, 2'h3},
    '{24'h400030, 1'b1, 2'h2, 32'h778899AA, 32'h00000000, 9, 4'h4, 2'h2},
    '{24'h000040, 1'b1, 2'h1, 32'h0000BEEF, 32'h00000000, 3, 4'h1, 2'h3},
    '{24'h600010, 1'b0, 2'h2, 32'h00000000, 32'h11223344, 5, 4'h8, 2'h0},
    '{24'h600015, 1'b0, 2'h0, 32'h00000000, 32'h000000AA, 3, 4'h8, 2'h0},
    '{24'h200020, 1'b0, 2'h1, 32'h00000000, 32'h00005566, 5, 4'h2, 2'h0},
    '{24'h400030, 1'b0, 2'h2, 32'h00000000, 32'h778899AA, 9, 4'h4, 2'h0},
    '{24'h400032, 1'b0, 2'h1, 32'h00000000, 32'h000099AA, 5, 4'h4, 2'h0},
    '{24'h000040, 1'b0, 2'h1, 32'h00000000, 32'h0000BEEF, 3, 4'h1, 2'h0},
    '{24'hFFB000, 1'b0, 2'h2, 32'h00000000, INT_DATA, 2, 4'h0, 2'h0},
    '{24'hFFF000, 1'b0, 2'h2, 32'h00000000, INT_DATA, 3, 4'h0, 2'h0}
  };

  always #25 i_clock = ~i_clock;

  ext_bus_ctrl i_ext_bus_ctrl (
    .i_clock, .i_rst, .i_advanced_mode, .i_rom_enable, .i_expansion_mode, .i_cfg_load,
    .i_area_unit_select, .i_onchip_ram_enable, .i_area_width_control,
    .i_area_state_control, .i_wait_control, .i_burst_rom_area0, .i_cs_direction,
    .i_req_valid, .i_req_addr, .i_req_write, .i_req_size, .i_req_wdata, .o_req_ready,
    .o_resp_valid, .o_resp_rdata, .o_int_access, .o_int_io, .i_int_rdata, .o_addr,
    .o_data_out, .o_data_oe_upper, .o_data_oe_lower, .i_data_in, .o_read_strobe_n,
    .o_upper_write_strobe_n, .o_lower_write_strobe_n, .o_chip_select_n, .o_chip_select_oe
  );

  ext_mem_model i_ext_mem_model (
    .i_clock(i_clock), .i_addr(o_addr), .i_data(o_data_out), .i_read_n(o_read_strobe_n),
    .i_upper_write_n(o_upper_write_strobe_n), .i_lower_write_n(o_lower_write_strobe_n),
    .i_narrow(i_area_width_control), .o_data(i_data_in)
  );

  task automatic report_and_stop();
    if (errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  task automatic run(input row_s r);
    int         n;
    logic [3:0] cs;
    logic [1:0] wr;
    @(posedge i_clock);
    i_req_valid <= 1'b1;
    i_req_addr <= r.a;
    i_req_write <= r.w;
    i_req_size <= r.sz;
    i_req_wdata <= r.wd;
    @(posedge i_clock);
    i_req_valid <= 1'b0;
    #1;
    n = 1;
    cs = ~o_chip_select_n;
    wr = {~o_upper_write_strobe_n, ~o_lower_write_strobe_n};
    do begin
      @(posedge i_clock);
      #1;
      n++;
      cs |= ~o_chip_select_n;
      wr |= {~o_upper_write_strobe_n, ~o_lower_write_strobe_n};
    end while (o_resp_valid !== 1'b1 && n < 40);
    chk(n == r.lat, "access length");
    chk(o_resp_rdata === r.rd, "read data");
    chk(cs === r.cs, "chip select");
    chk(wr === r.wr, "write strobes");
  endtask

  task automatic cfg(input logic unit, input logic ram);
    @(posedge i_clock);
    i_cfg_load <= 1'b1;
    i_area_unit_select <= unit;
    i_onchip_ram_enable <= ram;
    i_cs_direction <= 4'hF;
    @(posedge i_clock);
    i_cfg_load <= 1'b0;
  endtask

  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      report_and_stop();
    end
  end

  initial begin
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (5) @(posedge i_clock);
    #1;
    chk(o_chip_select_oe === 4'h1, "chip select direction after reset");
    chk(o_req_ready === 1'b1 && o_chip_select_n === 4'hF, "idle after reset");
    run('{24'h600060, 1'b1, 2'h1, 32'h00001234, 32'h00000000, 7, 4'h8, 2'h3});
    cfg(1'b1, 1'b1);
    #1;
    chk(o_chip_select_oe === 4'hF, "chip select direction set");
    foreach (rows[i]) run(rows[i]);
    cfg(1'b0, 1'b0);
    run('{24'hFFB004, 1'b1, 2'h1, 32'h0000CAFE, 32'h00000000, 3, 4'h0, 2'h3});
    run('{24'hFFB004, 1'b0, 2'h1, 32'h00000000, 32'h0000CAFE, 3, 4'h0, 2'h0});
    run('{24'h020050, 1'b1, 2'h1, 32'h00001357, 32'h00000000, 5, 4'h2, 2'h3});
    run('{24'h020050, 1'b0, 2'h1, 32'h00000000, 32'h00001357, 5, 4'h2, 2'h0});
    @(posedge i_clock);
    i_rst <= 1'b1;
    i_advanced_mode <= 1'b0;
    i_rom_enable <= 1'b1;
    i_area_width_control <= 8'hFF;
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (5) @(posedge i_clock);
    #1;
    chk(o_chip_select_oe === 4'h0 && o_req_ready === 1'b1, "direction with ROM on");
    run('{24'h000100, 1'b0, 2'h1, 32'h00000000, INT_DATA, 2, 4'h0, 2'h0});
    run('{24'h00C010, 1'b1, 2'h1, 32'h00002468, 32'h00000000, 13, 4'h1, 2'h2});
    run('{24'h00C010, 1'b0, 2'h1, 32'h00000000, 32'h00002468, 13, 4'h1, 2'h0});
    report_and_stop();
  end
endmodule
